// ===== rtl/pie_instruction_executor.sv
// Function
// RULE1 - Each step is opcode, tens address digit, units address digit.
// RULE2 - Overflow halts execution and lights the alarm lamp.
// RULE3 - Keyboard step halts, lights keyboard lamp, waits for motor bar.
// RULE4 - Motor bar loads keyboard into low 11 digits, top digit zero.
// RULE5 - Minus bar makes the entered value negative.
// RULE6 - Entered value printed, then carriage moves by the pressed bar.
// RULE7 - Keyboard step with units 0 does all but the printing.
// RULE8 - Write replaces the addressed word with the accumulator.
// RULE9 - Read replaces the accumulator with the addressed word.
// RULE10 - Transfer replaces multiplicand register with the accumulator.
// RULE11 - Transfer alarms when accumulator magnitude is 1.0 or more.
// RULE12 - Print outputs accumulator, then moves carriage by tens bar.
// RULE13 - Empty tens field or value not 1, 3, 4 selects bar 2.
// RULE14 - Print with units 0 moves the carriage without printing.
// RULE15 - Print-and-halt stops once carriage motion is finished.
// RULE16 - Accumulator holds 12 decimal digits plus sign.
// RULE17 - Memory holds 100 words, addresses 00 to 99, 12 digits plus sign.
// RULE18 - Multiplicand register and keyboard hold 11 digits.
// RULE19 - Words are twelve BCD digits plus a separate sign bit.
// RULE20 - Operator continue resumes execution after any halt; the keyboard wait ignores it and ends only on the motor bar.
module pie_instruction_executor import pie_pkg::*; (
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   input  wire logic              instrValid,
   output logic                   instrReady,
   input  wire logic [2:0]        opCode,
   input  wire logic [3:0]        tensDigit,
   input  wire logic              tensEmpty,
   input  wire logic [3:0]        unitsDigit,
   input  wire logic              unitsHalt,
   input  wire logic [KBD_W-1:0]  kbdDigits,
   input  wire logic              minusBar,
   input  wire logic              motorBarPress,
   input  wire logic [1:0]        motorBarSel,
   input  wire logic              carriageDone,
   input  wire logic              continueReq,
   output logic                   printReq,
   output logic [WORD_W-1:0]      printDigits,
   output logic                   printSign,
   output logic                   carriageReq,
   output logic [2:0]             carriageBar,
   output logic                   alarmLamp,
   output logic                   keyboardLamp,
   output logic                   haltLamp,
   output logic [WORD_W-1:0]      accDigits,
   output logic                   accSign,
   output logic [KBD_W-1:0]       mcandDigits,
   output logic                   mcandSign
);
   // Motor bar from the tens field; anything unusual falls back to bar 2
   function automatic logic [2:0] pie_bar_sel(input logic [3:0] d,
                                              input logic       none);
      if (!none && (d == BAR_ONE || d == BAR_THREE || d == BAR_FOUR)) begin
         return d[2:0];
      end
      return BAR_DEFAULT;
   endfunction : pie_bar_sel

   pie_state_type      state_ff, nxt_state;
   logic [WORD_W-1:0]  acc_ff, nxt_acc;
   logic               accSign_ff, nxt_accSign;
   logic [KBD_W-1:0]   mcand_ff, nxt_mcand;
   logic               mcandSign_ff, nxt_mcandSign;
   logic [2:0]         bar_ff, nxt_bar;
   logic               haltAfter_ff, nxt_haltAfter;
   logic               kbdPrint_ff, nxt_kbdPrint;

   pie_mem_if memBus ();

   pie_word_memory #(
      .WORDS (MEM_WORDS)
   ) uMemory (
      .clk_sys (clk_sys),
      .reset_n (reset_n),
      .mem     (memBus.exec)
   );

   // Step decode: opcode plus two address digits
   wire        taken    = instrValid && (state_ff == ST_IDLE);
   wire        unitsNil = (unitsDigit == DIGIT_ZERO);
   wire        isKbd    = taken && (opCode == OP_KBD);   // RULE1
   wire        isWrite  = taken && (opCode == OP_WRITE); // RULE1
   wire        isRead   = taken && (opCode == OP_READ);  // RULE1
   wire        isBxfer  = taken && (opCode == OP_BXFER); // RULE1
   wire        isPrint  = taken && (opCode == OP_PRINT); // RULE1
   wire [2:0]  printBar = pie_bar_sel(tensDigit, tensEmpty); // RULE13
   wire        kbdLoad  = (state_ff == ST_KWAIT) && motorBarPress;
   // Top digit nonzero means magnitude of 1.0 or more
   wire        tooWide  = acc_ff[WORD_W-1 -: DIGIT_W] != DIGIT_ZERO; // RULE11

   // Memory address = tens * 10 + units
   assign memBus.addr   = ADDR_W'(tensDigit * TENS_SCALE)
                        + ADDR_W'(unitsDigit); // RULE1
   assign memBus.wrEn   = isWrite;                       // RULE8
   assign memBus.wrData = {accSign_ff, acc_ff};          // RULE19

   // Sequencer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (isKbd) begin
               nxt_state = ST_KWAIT;                     // RULE3
            end else if (isBxfer && tooWide) begin
               nxt_state = ST_ALARM;                     // RULE2
            end else if (isPrint) begin
               nxt_state = unitsNil ? ST_MOVE : ST_PRINT; // RULE14
            end
         end
         ST_KWAIT: begin
            // Latched choice; the step pins may have moved on by now
            if (motorBarPress) begin
               nxt_state = kbdPrint_ff ? ST_PRINT : ST_MOVE; // RULE7
            end
         end
         ST_PRINT: nxt_state = ST_MOVE;                  // RULE6
         ST_MOVE:  nxt_state = ST_MWAIT;
         ST_MWAIT: begin
            if (carriageDone) begin
               nxt_state = haltAfter_ff ? ST_HALT : ST_IDLE; // RULE15
            end
         end
         ST_HALT, ST_ALARM: begin
            if (continueReq) begin
               nxt_state = ST_IDLE;                      // RULE20
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // Accumulator and multiplicand next values
   always_comb begin
      nxt_acc       = acc_ff;
      nxt_accSign   = accSign_ff;
      nxt_mcand     = mcand_ff;
      nxt_mcandSign = mcandSign_ff;
      if (kbdLoad) begin
         nxt_acc     = {DIGIT_ZERO, kbdDigits};          // RULE4
         nxt_accSign = minusBar;                         // RULE5
      end else if (isRead) begin
         nxt_acc     = memBus.rdData[WORD_W-1:0];        // RULE9
         nxt_accSign = memBus.rdData[WORD_W];            // RULE9
      end
      if (isBxfer) begin
         // Copy still happens on alarm; register is 11 digits wide
         nxt_mcand     = acc_ff[KBD_W-1:0];              // RULE10
         nxt_mcandSign = accSign_ff;                     // RULE10
      end
   end

   // Carriage bar, halt-after and keyboard print choice
   always_comb begin
      nxt_bar       = bar_ff;
      nxt_haltAfter = haltAfter_ff;
      nxt_kbdPrint  = kbdPrint_ff;
      if (isPrint) begin
         nxt_bar       = printBar;                       // RULE12
         nxt_haltAfter = unitsHalt;                      // RULE15
      end else if (isKbd) begin
         nxt_haltAfter = 1'b0;
         nxt_kbdPrint  = !unitsNil;                      // RULE7
      end
      if (kbdLoad) begin
         nxt_bar = {1'b0, motorBarSel} + BAR_OFFSET;     // RULE6
      end
   end

   // State and control flops
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_ff     <= ST_IDLE;
         bar_ff       <= BAR_DEFAULT;
         haltAfter_ff <= 1'b0;
         kbdPrint_ff  <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         bar_ff       <= nxt_bar;
         haltAfter_ff <= nxt_haltAfter;
         kbdPrint_ff  <= nxt_kbdPrint;
      end
   end

   // Data flops
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         acc_ff       <= '0;
         accSign_ff   <= 1'b0;
         mcand_ff     <= '0;
         mcandSign_ff <= 1'b0;
      end else begin
         acc_ff       <= nxt_acc;                        // RULE16
         accSign_ff   <= nxt_accSign;
         mcand_ff     <= nxt_mcand;                      // RULE18
         mcandSign_ff <= nxt_mcandSign;
      end
   end

   // Lamps and printer; print data is the accumulator itself
   assign instrReady   = (state_ff == ST_IDLE);
   assign keyboardLamp = (state_ff == ST_KWAIT);         // RULE3
   assign alarmLamp    = (state_ff == ST_ALARM);         // RULE2
   assign haltLamp     = (state_ff == ST_HALT);
   assign printReq     = (state_ff == ST_PRINT);
   assign carriageReq  = (state_ff == ST_MOVE);
   assign carriageBar  = bar_ff;
   assign printDigits  = acc_ff;
   assign printSign    = accSign_ff;
   assign accDigits    = acc_ff;
   assign accSign      = accSign_ff;
   assign mcandDigits  = mcand_ff;
   assign mcandSign    = mcandSign_ff;

   // Checks
   sequence s_print_move;
      printReq ##1 carriageReq;
   endsequence

   sequence s_move_only;
      !printReq && carriageReq;
   endsequence

   a_kbd_wait: assert property (@(posedge clk_sys) disable iff (!reset_n)
      isKbd |=> keyboardLamp && !instrReady)
      else $error("keyboard step did not wait"); // RULE3
   a_kbd_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
      keyboardLamp && !motorBarPress |=> keyboardLamp && !instrReady)
      else $error("keyboard wait left without a bar"); // RULE3
   a_kbd_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      kbdLoad |=> acc_ff == {DIGIT_ZERO, $past(kbdDigits)}
               && accSign_ff == $past(minusBar))
      else $error("keyboard value not loaded"); // RULE4
   a_kbd_print: assert property (@(posedge clk_sys) disable iff (!reset_n)
      kbdLoad && kbdPrint_ff |=> s_print_move)
      else $error("keyboard entry not printed then moved"); // RULE6
   a_kbd_noprint: assert property (@(posedge clk_sys) disable iff (!reset_n)
      kbdLoad && !kbdPrint_ff |=> s_move_only)
      else $error("non-print keyboard entry printed"); // RULE7
   a_read_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
      isRead |=> {accSign_ff, acc_ff} == $past(memBus.rdData))
      else $error("read did not load accumulator"); // RULE9
   a_bxfer_copy: assert property (@(posedge clk_sys) disable iff (!reset_n)
      isBxfer |=> mcand_ff == $past(acc_ff[KBD_W-1:0])
               && acc_ff == $past(acc_ff))
      else $error("multiplicand transfer wrong"); // RULE10
   a_bxfer_alarm: assert property (@(posedge clk_sys) disable iff (!reset_n)
      isBxfer |=> alarmLamp == $past(tooWide))
      else $error("range alarm wrong"); // RULE11
   a_alarm_stop: assert property (@(posedge clk_sys) disable iff (!reset_n)
      alarmLamp && !continueReq |=> alarmLamp && !instrReady)
      else $error("alarm did not hold execution"); // RULE2
   a_print_bar: assert property (@(posedge clk_sys) disable iff (!reset_n)
      isPrint |=> carriageBar == $past(printBar)
               && (carriageBar inside {3'h1, 3'h2, 3'h3, 3'h4}))
      else $error("wrong motor bar"); // RULE13
   a_print_seq: assert property (@(posedge clk_sys) disable iff (!reset_n)
      isPrint && !unitsNil |=> s_print_move)
      else $error("print not followed by move"); // RULE12
   a_print_dummy: assert property (@(posedge clk_sys) disable iff (!reset_n)
      isPrint && unitsNil |=> s_move_only)
      else $error("non-print step printed"); // RULE14
   a_print_halt: assert property (@(posedge clk_sys) disable iff (!reset_n)
      state_ff == ST_MWAIT && carriageDone |=> haltLamp == $past(haltAfter_ff))
      else $error("halt after carriage wrong"); // RULE15
endmodule : pie_instruction_executor

// ===== rtl/pie_pkg.sv
package pie_pkg;
   // Word layout: BCD digits, sign held apart
   localparam int ACC_DIGITS = 12;
   localparam int KBD_DIGITS = 11;
   localparam int DIGIT_W    = 4;
   localparam int WORD_W     = ACC_DIGITS * DIGIT_W;
   localparam int KBD_W      = KBD_DIGITS * DIGIT_W;
   localparam int MEM_WORDS  = 100;
   localparam int ADDR_W     = 7;
   localparam int TENS_SCALE = 10;

   // Field values seen in the address digits
   localparam logic [3:0] DIGIT_ZERO  = 4'h0;
   localparam logic [3:0] BAR_ONE     = 4'h1;
   localparam logic [3:0] BAR_THREE   = 4'h3;
   localparam logic [3:0] BAR_FOUR    = 4'h4;
   localparam logic [2:0] BAR_DEFAULT = 3'h2;
   localparam logic [2:0] BAR_OFFSET  = 3'h1;

   // Operation codes on the pinboard's first area
   typedef enum logic [2:0] {
      OP_NONE  = 3'b000,
      OP_KBD   = 3'b001,
      OP_WRITE = 3'b010,
      OP_READ  = 3'b011,
      OP_BXFER = 3'b100,
      OP_PRINT = 3'b101
   } pie_op_type;

   // Sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_KWAIT = 3'b001,
      ST_PRINT = 3'b010,
      ST_MOVE  = 3'b011,
      ST_MWAIT = 3'b100,
      ST_HALT  = 3'b101,
      ST_ALARM = 3'b110
   } pie_state_type;
endpackage : pie_pkg

// ===== rtl/pie_mem_if.sv
interface pie_mem_if import pie_pkg::*; ();
   logic [ADDR_W-1:0] addr;
   logic              wrEn;
   logic [WORD_W:0]   wrData;
   logic [WORD_W:0]   rdData;

   modport exec  (output addr, output wrEn, output wrData, input rdData);
   modport store (input addr, input wrEn, input wrData, output rdData);
endinterface : pie_mem_if

// ===== rtl/pie_word_memory.sv
module pie_word_memory import pie_pkg::*; #(
   parameter int WORDS = MEM_WORDS
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   pie_mem_if.store mem
);
   // Sign in the top bit, BCD digits below; drum contents have no reset
   logic [WORD_W:0] words [WORDS]; // RULE17
   wire             inRange = int'(mem.addr) < WORDS;

   // One-cycle write replaces the old word whole, erase included
   always_ff @(posedge clk_sys) begin
      if (mem.wrEn && inRange) begin
         words[mem.addr] <= mem.wrData; // RULE8
      end
   end

   // Out-of-range addresses read as zero rather than X
   assign mem.rdData = inRange ? words[mem.addr] : '0;

   a_mem_store: assert property (@(posedge clk_sys) disable iff (!reset_n)
      mem.wrEn && inRange ##1 mem.addr == $past(mem.addr)
      |-> mem.rdData == $past(mem.wrData))
      else $error("stored word not read back"); // RULE8
endmodule : pie_word_memory

// ===== verification/pie_operator_model.sv
// Operator at the keyboard and the printer carriage
module pie_operator_model import pie_pkg::*; (
   input  wire logic             clk_sys,
   input  wire logic             keyboardLamp,
   input  wire logic             carriageReq,
   input  wire logic             slow,
   input  wire logic [KBD_W-1:0] kbdValue,
   input  wire logic             minusIn,
   input  wire logic [1:0]       barIn,
   output logic [KBD_W-1:0]      kbdDigits,
   output logic                  minusBar,
   output logic                  motorBarPress,
   output logic [1:0]            motorBarSel,
   output logic                  carriageDone
);
   timeunit 1ns;
   timeprecision 1ns;

   // Bar pressed only while the lamp is lit, then keys let go
   initial begin
      {kbdDigits, minusBar, motorBarSel, motorBarPress} = '0;
      forever begin
         @(negedge clk_sys);
         if (keyboardLamp === 1'b1) begin
            repeat (slow ? 4 : 1) @(negedge clk_sys);
            {kbdDigits, minusBar, motorBarSel} = {kbdValue, minusIn, barIn};
            motorBarPress = 1'b1;
            @(negedge clk_sys);
            // Released keys must not keep showing the old value
            {kbdDigits, minusBar, motorBarSel} =
               ~{kbdDigits, minusBar, motorBarSel};
            motorBarPress = 1'b0;
         end
      end
   end

   // Carriage motion takes at least one cycle after the request
   initial begin
      carriageDone = 1'b0;
      forever begin
         @(negedge clk_sys);
         if (carriageReq === 1'b1) begin
            repeat (slow ? 5 : 1) @(negedge clk_sys);
            carriageDone = 1'b1;
            @(negedge clk_sys);
            carriageDone = 1'b0;
         end
      end
   end
endmodule : pie_operator_model

// ===== verification/pinboard_instruction_executor_tb.sv
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
   $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module pinboard_instruction_executor_tb import pie_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic kind; logic [WORD_W:0] val;} pie_note_type;

   logic             clk_sys, reset_n, instrValid, tensEmpty, unitsHalt;
   logic             continueReq, slow, minusIn;
   logic [2:0]       opCode;
   logic [3:0]       tensDigit, unitsDigit;
   logic [1:0]       barIn;
   logic [KBD_W-1:0] kbdValue, kbdDigits, mcandDigits;
   logic [WORD_W-1:0] printDigits, accDigits;
   logic [2:0]       carriageBar;
   logic             instrReady, minusBar, motorBarPress, carriageDone;
   logic [1:0]       motorBarSel;
   logic             printReq, printSign, carriageReq, alarmLamp;
   logic             keyboardLamp, haltLamp, accSign, mcandSign;
   logic [WORD_W:0]  acc, vals[4];
   pie_note_type     notes[$];
   int               errors, comparisons, seed;

   pie_instruction_executor i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .instrValid(instrValid), .instrReady(instrReady), .opCode(opCode),
      .tensDigit(tensDigit), .tensEmpty(tensEmpty), .unitsDigit(unitsDigit),
      .unitsHalt(unitsHalt), .kbdDigits(kbdDigits), .minusBar(minusBar),
      .motorBarPress(motorBarPress), .motorBarSel(motorBarSel),
      .carriageDone(carriageDone), .continueReq(continueReq),
      .printReq(printReq), .printDigits(printDigits), .printSign(printSign),
      .carriageReq(carriageReq), .carriageBar(carriageBar),
      .alarmLamp(alarmLamp), .keyboardLamp(keyboardLamp),
      .haltLamp(haltLamp), .accDigits(accDigits), .accSign(accSign),
      .mcandDigits(mcandDigits), .mcandSign(mcandSign));

   pie_operator_model i_operator (.clk_sys(clk_sys),
      .keyboardLamp(keyboardLamp), .carriageReq(carriageReq), .slow(slow),
      .kbdValue(kbdValue), .minusIn(minusIn), .barIn(barIn),
      .kbdDigits(kbdDigits), .minusBar(minusBar),
      .motorBarPress(motorBarPress), .motorBarSel(motorBarSel),
      .carriageDone(carriageDone));

   // 20 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic tally_and_finish();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : tally_and_finish

   // Print and carriage events matched against the oldest note
   task automatic see(input pie_note_type got);
      pie_note_type exp;
      exp = (notes.size() > 0) ? notes.pop_front() : ~got;
      `CHK(got, exp)
   endtask : see

   initial begin
      forever begin
         @(negedge clk_sys);
         if (printReq === 1'b1) see({1'b0, printSign, printDigits});
         if (carriageReq === 1'b1) see({1'b1, {(WORD_W-2){1'b0}}, carriageBar});
      end
   end

   // Bounded wait on ready or halt lamp; a hang ends the run
   task automatic waitFor(input logic halt);
      int n;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while ((halt ? haltLamp : instrReady) !== 1'b1 && n < 300);
      if (n >= 300) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, 0, 1);
         tally_and_finish();
      end
   endtask : waitFor

   task automatic step(input logic [2:0] op, input logic [3:0] t, u,
                       input logic te, uh);
      @(negedge clk_sys);
      {instrValid, opCode, tensDigit, unitsDigit} = {1'b1, op, t, u};
      {tensEmpty, unitsHalt} = {te, uh};
      @(posedge clk_sys);
   endtask : step

   task automatic rest();
      @(negedge clk_sys);
      instrValid = 1'b0;
   endtask : rest

   // Keyboard entry with random digits and sign
   task automatic kbd(input logic [3:0] u, input logic [1:0] bar);
      for (int k = 0; k < KBD_DIGITS; k++) kbdValue[k*4 +: 4] = 4'($urandom % 10);
      {minusIn, slow, barIn} = {1'($urandom), 1'($urandom), bar};
      acc = {minusIn, 4'h0, kbdValue};
      step(OP_KBD, 4'h0, u, 1'b1, 1'b0);
      rest();
      `CHK({keyboardLamp, instrReady}, 2'b10)
      if (u != 4'h0) notes.push_back({1'b0, acc});
      notes.push_back({1'b1, {(WORD_W-2){1'b0}}, 3'(bar) + 3'h1});
      waitFor(1'b0);
      `CHK({accSign, accDigits}, acc)
   endtask : kbd

   // Print, dummy print and print-and-halt
   task automatic prt(input logic [3:0] t, u, input logic te, uh);
      logic [2:0] bar;
      bar = (!te && (t == 1 || t == 3 || t == 4)) ? t[2:0] : 3'h2;
      slow = 1'($urandom);
      if (u != 4'h0) notes.push_back({1'b0, acc});
      notes.push_back({1'b1, {(WORD_W-2){1'b0}}, bar});
      step(OP_PRINT, t, u, te, uh);
      rest();
      waitFor(uh);
      if (uh) begin
         `CHK({instrReady, notes.size()}, {1'b0, 32'd0})
         continueReq = 1'b1;
         @(negedge clk_sys);
         continueReq = 1'b0;
         waitFor(1'b0);
         `CHK(haltLamp, 1'b0)
      end
      `CHK({accSign, accDigits}, acc)
   endtask : prt

   initial begin
      {instrValid, opCode, tensDigit, unitsDigit, tensEmpty} = '0;
      {unitsHalt, continueReq, slow, minusIn, barIn, kbdValue} = '0;
      {reset_n, errors, comparisons} = '0;
      seed = $urandom(32'h0a4b);
      repeat (4) @(negedge clk_sys);
      `CHK({instrReady, keyboardLamp, haltLamp, alarmLamp}, 4'h8)
      `CHK({carriageBar, accSign, accDigits}, {3'h2, 49'h0})
      reset_n = 1'b1;
      // Four bars, addresses 48, 84, 09 and 90, then read back
      for (int i = 0; i < 4; i++) begin
         kbd(i[0] ? 4'h0 : 4'h7, 2'(i));
         vals[i] = acc;
         step(OP_WRITE, 4'(i < 2 ? 4 + 4 * i : 9 * (i - 2)),
              4'(i < 2 ? 8 - 4 * i : 9 * (3 - i)), 1'b0, 1'b0);
         // Address held one more edge so the stored word is read back
         rest();
      end
      for (int i = 0; i < 4; i++) begin
         step(OP_READ, 4'(i < 2 ? 4 + 4 * i : 9 * (i - 2)),
              4'(i < 2 ? 8 - 4 * i : 9 * (3 - i)), 1'b0, 1'b0);
         @(negedge clk_sys);
         `CHK({accSign, accDigits}, vals[i])
      end
      rest();
      acc = vals[3];
      // Multiplicand transfer keeps the accumulator
      kbd(4'h5, 2'h2);
      step(OP_BXFER, 4'h0, 4'h0, 1'b1, 1'b0);
      rest();
      `CHK({mcandSign, mcandDigits}, {acc[WORD_W], acc[KBD_W-1:0]})
      `CHK({alarmLamp, accSign, accDigits}, {1'b0, acc})
      // Unused opcode is taken at once and leaves the accumulator alone
      step(3'h6, 4'h1, 4'h2, 1'b0, 1'b0);
      rest();
      `CHK({instrReady, accSign, accDigits}, {1'b1, acc})
      // Every tens value, empty field, non-print and halt variants
      for (int i = 0; i < 11; i++) begin
         prt(4'(i % 10), (i % 3 == 0) ? 4'h0 : 4'h6, i == 10, i == 7);
      end
      `CHK(notes.size(), 0)
      tally_and_finish();
   end
endmodule : pinboard_instruction_executor_tb
